// File: src/rip_cfg.svh
// Offsets, field positions, command codes, status words and sizes
`ifndef RIP_CFG_SVH
`define RIP_CFG_SVH
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_PIN 8'h10
`define A_REC 8'h40
`define INS_INC 8'h32
`define INS_VER 8'h20
`define REC_LEN 8'h04
`define NREC 4
`define NPIN 4
`define PIN_LEN 8'h08
`define LC_LIM 8'h80
`define TRIES 2'h3
`define SW_OK 16'h9000
`define SW_LEN 16'h6700
`define SW_PAR 16'h6b00
`define SW_NOFILE 16'h6a82
`define SW_NOREF 16'h6a88
`define SW_SEC 16'h6982
`define SW_BLK 16'h6983
`define SW_COND 16'h6985
`define SW_INS 16'h6d00
`define SW_OVF 16'h9850
`define SW_TRY 12'h63c
`define CT_ALLOW 0
`define CT_NEEDPIN 1
`define CT_PSEL 3:2
`define CT_PDIS 7:4
`define CT_FILE_ID 12:8
`define CT_NEWEST 17:16
`endif

// File: src/rip_pkg.sv
// Types shared by the record increase and PIN verification block
package rip_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_COLLECT, ST_EXEC, ST_SEND, ST_STATUS} state_t;
  typedef logic [1:0] idx_t;
endpackage

// File: src/record_increase_pin_verify.sv
// Card-side interpreter for the record increase and PIN verification commands
// Functional notes
// - Increase adds command value to newest record, stores sum in oldest record.
// - After increase the written record becomes newest, that is record 1.
// - Increase runs only when the file's increase access condition is granted and met.
// - Increase refused when the sum would pass the all-FF record maximum.
// - Increase P1 zero or short file id form only, P2 zero; others refused.
// - Increase length between 1 and 127 bytes and within the record length.
// - Increase answer is new record bytes followed by the added value bytes.
// - PIN comparison only when that PIN is neither disabled nor blocked.
// - PIN-protected increase allowed only after that PIN verified, unless disabled.
// - Correct PIN restores the remaining attempts to three.
// - Wrong PIN decrements attempts, answering 63C2 then 63C1.
// - Third consecutive wrong PIN blocks it and answers 63C0.
// - Verify with data on blocked PIN answers 6983; its access stays unmet.
// - Empty verify only reports attempts left as 63CX, changing nothing.
// - Empty verify on a blocked PIN answers 6983.
// - Verify P2 bits 6 and 5 zero, key 01 to 1F; zero unsupported.
`timescale 1ns/10ps
`include "rip_cfg.svh"

module record_increase_pin_verify
  import rip_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_nv_init,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_cmd_start,
  input wire logic [7:0] i_ins,
  input wire logic [7:0] i_p1,
  input wire logic [7:0] i_p2,
  input wire logic [7:0] i_lc,
  input wire logic i_cmd_data_valid,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_busy,
  output logic o_resp_valid,
  output logic [7:0] o_resp_byte,
  input wire logic i_resp_ready,
  output logic o_sw_valid,
  output logic [15:0] o_sw
);

  // ****************************************
  // State
  // ****************************************
  state_t st, next_st;
  logic [7:0] ins_q, p1_q, p2_q, lc_q, cnt, idx;
  logic [7:0] next_ins, next_p1, next_p2, next_lc, next_cnt, next_idx;
  logic [63:0] dbuf, next_dbuf;
  logic [15:0] sw_q, next_sw;
  logic [7:0] resp_q, next_resp;
  logic [31:0] rec [`NREC];
  logic [31:0] next_rec [`NREC];
  idx_t newest, next_newest;
  logic allow, needpin, next_allow, next_needpin;
  idx_t psel, next_psel;
  logic [3:0] pdis, verified, blocked, next_pdis, next_verified, next_blocked;
  logic [4:0] file_id, next_file_id;
  logic [63:0] pin_ref [`NPIN];
  logic [63:0] next_pin_ref [`NPIN];
  logic [1:0] tries [`NPIN];
  logic [1:0] next_tries [`NPIN];
  logic [31:0] next_rdata;

  idx_t oldest, pidx;
  logic [32:0] sum;
  logic [4:0] key;
  logic access_met, pin_match;
  logic [7:0] total;

  assign oldest = newest + 2'h1;
  assign sum = {1'b0, rec[newest]} + {1'b0, dbuf[31:0]};
  assign key = p2_q[4:0];
  assign pidx = 2'(key - 5'h1);
  assign pin_match = dbuf == pin_ref[pidx];
  assign total = `REC_LEN + lc_q;
  assign access_met = allow && (!needpin || pdis[psel] || (verified[psel] && !blocked[psel]));

  assign o_cmd_busy = st != ST_IDLE;
  assign o_resp_valid = st == ST_SEND;
  assign o_resp_byte = resp_q;
  assign o_sw_valid = st == ST_STATUS;
  assign o_sw = sw_q;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [7:0] sh;
    logic [31:0] nv;
    sh = 8'h00;
    nv = 32'h0;
    next_st = st;
    next_ins = ins_q;
    next_p1 = p1_q;
    next_p2 = p2_q;
    next_lc = lc_q;
    next_cnt = cnt;
    next_idx = idx;
    next_dbuf = dbuf;
    next_sw = sw_q;
    next_rec = rec;
    next_newest = newest;
    next_allow = allow;
    next_needpin = needpin;
    next_psel = psel;
    next_pdis = pdis;
    next_file_id = file_id;
    next_verified = verified;
    next_blocked = blocked;
    next_pin_ref = pin_ref;
    next_tries = tries;
    next_rdata = 32'h0;
    if (i_wr)
    begin
      if (i_addr == `A_CTRL)
      begin
        next_allow = i_wdata[`CT_ALLOW];
        next_needpin = i_wdata[`CT_NEEDPIN];
        next_psel = i_wdata[`CT_PSEL];
        next_pdis = i_wdata[`CT_PDIS];
        next_file_id = i_wdata[`CT_FILE_ID];
        next_newest = i_wdata[`CT_NEWEST];
      end
      for (int k = 0; k < `NPIN; k++)
      begin
        if (i_addr == 8'(`A_PIN + 8 * k))
          next_pin_ref[k][63:32] = i_wdata;
        if (i_addr == 8'(`A_PIN + 8 * k + 4))
          next_pin_ref[k][31:0] = i_wdata;
      end
      for (int r = 0; r < `NREC; r++)
        if (i_addr == 8'(`A_REC + 4 * r))
          next_rec[r] = i_wdata;
    end
    if (i_rd)
    begin
      if (i_addr == `A_CTRL)
        next_rdata = {14'h0, newest, 3'h0, file_id, pdis, psel, needpin, allow};
      else if (i_addr == `A_STAT)
        next_rdata = {sw_q, verified, blocked, tries[3], tries[2], tries[1], tries[0]};
      for (int r = 0; r < `NREC; r++)
        if (i_addr == 8'(`A_REC + 4 * r))
          next_rdata = rec[r];
    end
    case (st)
      ST_IDLE:
      begin
        if (i_cmd_start)
        begin
          next_ins = i_ins;
          next_p1 = i_p1;
          next_p2 = i_p2;
          next_lc = i_lc;
          next_cnt = 8'h00;
          next_dbuf = 64'h0;
          next_st = (i_lc == 8'h00) ? ST_EXEC : ST_COLLECT;
        end
      end
      ST_COLLECT:
      begin
        if (i_cmd_data_valid)
        begin
          if (cnt < `PIN_LEN)
            next_dbuf = {dbuf[55:0], i_cmd_data};
          next_cnt = cnt + 8'h01;
          if (cnt == lc_q - 8'h01)
            next_st = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        next_st = ST_STATUS;
        next_sw = `SW_OK;
        if (ins_q == `INS_INC)
        begin
          if (p2_q != 8'h00 || !(p1_q == 8'h00 || p1_q[7:5] == 3'b100))
            next_sw = `SW_PAR;
          else if (lc_q == 8'h00 || lc_q >= `LC_LIM || lc_q > `REC_LEN)
            next_sw = `SW_LEN;
          else if (p1_q != 8'h00 && p1_q[4:0] != file_id)
            next_sw = `SW_NOFILE;
          else if (!access_met)
            next_sw = `SW_SEC;
          else if (sum[32])
            next_sw = `SW_OVF;
          else
          begin
            next_rec[oldest] = sum[31:0];
            next_newest = oldest;
            next_idx = 8'h00;
            next_st = ST_SEND;
          end
        end
        else if (ins_q == `INS_VER)
        begin
          if (p1_q != 8'h00 || p2_q[6:5] != 2'b00 || key == 5'h00)
            next_sw = `SW_PAR;
          else if (key > 5'(`NPIN))
            next_sw = `SW_NOREF;
          else if (lc_q == 8'h00)
          begin
            if (blocked[pidx])
              next_sw = `SW_BLK;
            else
              next_sw = {`SW_TRY, 2'b00, tries[pidx]};
          end
          else if (lc_q != `PIN_LEN)
            next_sw = `SW_LEN;
          else if (blocked[pidx])
            next_sw = `SW_BLK;
          else if (pdis[pidx])
            next_sw = `SW_COND;
          else if (pin_match)
          begin
            next_tries[pidx] = `TRIES;
            next_verified[pidx] = 1'b1;
          end
          else
          begin
            next_tries[pidx] = tries[pidx] - 2'h1;
            next_verified[pidx] = 1'b0;
            next_sw = {`SW_TRY, 2'b00, 2'(tries[pidx] - 2'h1)};
            if (tries[pidx] == 2'h1)
              next_blocked[pidx] = 1'b1;
          end
        end
        else
          next_sw = `SW_INS;
      end
      ST_SEND:
      begin
        if (i_resp_ready)
        begin
          if (idx == total - 8'h01)
            next_st = ST_STATUS;
          else
            next_idx = idx + 8'h01;
        end
      end
      ST_STATUS:
        next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
    nv = next_rec[next_newest];
    if (next_idx < `REC_LEN)
    begin
      sh = `REC_LEN - 8'h01 - next_idx;
      next_resp = 8'(nv >> {sh, 3'b000});
    end
    else
    begin
      sh = lc_q - 8'h01 - (next_idx - `REC_LEN);
      next_resp = 8'(dbuf >> {sh, 3'b000});
    end
    if (next_st != ST_SEND)
      next_resp = resp_q;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      st <= ST_IDLE;
      ins_q <= 8'h00;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
      lc_q <= 8'h00;
      cnt <= 8'h00;
      idx <= 8'h00;
      dbuf <= 64'h0;
      sw_q <= `SW_OK;
      resp_q <= 8'h00;
      rec <= '{default: 32'h0};
      newest <= 2'h0;
      allow <= 1'b0;
      needpin <= 1'b0;
      psel <= 2'h0;
      pdis <= 4'h0;
      file_id <= 5'h00;
      verified <= 4'h0;
      o_rdata <= 32'h0;
    end
    else
    begin
      st <= next_st;
      ins_q <= next_ins;
      p1_q <= next_p1;
      p2_q <= next_p2;
      lc_q <= next_lc;
      cnt <= next_cnt;
      idx <= next_idx;
      dbuf <= next_dbuf;
      sw_q <= next_sw;
      resp_q <= next_resp;
      rec <= next_rec;
      newest <= next_newest;
      allow <= next_allow;
      needpin <= next_needpin;
      psel <= next_psel;
      pdis <= next_pdis;
      file_id <= next_file_id;
      verified <= next_verified;
      o_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_nv_init)
    begin
      tries <= '{default: `TRIES};
      blocked <= 4'h0;
      pin_ref <= '{default: 64'h0};
    end
    else
    begin
      tries <= next_tries;
      blocked <= next_blocked;
      pin_ref <= next_pin_ref;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] sent;
  logic inc_ok, ver_data;
  assign inc_ok = st == ST_EXEC && ins_q == `INS_INC && next_st == ST_SEND;
  assign ver_data = st == ST_EXEC && ins_q == `INS_VER && lc_q == `PIN_LEN && p1_q == 8'h00
    && p2_q[6:5] == 2'b00 && key != 5'h00 && key <= 5'(`NPIN);

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || st == ST_IDLE)
      sent <= 8'h00;
    else if (o_resp_valid && i_resp_ready)
      sent <= sent + 8'h01;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset || i_nv_init);

  a_sum_written: assert property (
    inc_ok |=> rec[newest] == $past(sum[31:0]) && o_resp_valid)
    else $error("increase sum not stored");
  a_pointer_moves: assert property (
    inc_ok |=> newest == $past(oldest))
    else $error("record pointer not moved");
  a_access_gate: assert property (
    inc_ok |-> allow && access_met)
    else $error("increase ran without access");
  a_max_refused: assert property (
    st == ST_EXEC && ins_q == `INS_INC && sum[32] |=> newest == $past(newest) && o_sw != `SW_OK)
    else $error("overflowing increase not refused");
  a_resp_length: assert property (
    o_sw_valid && ins_q == `INS_INC && o_sw == `SW_OK |-> sent == total)
    else $error("increase answer length wrong");
  a_retry_restore: assert property (
    ver_data && !blocked[pidx] && !pdis[pidx] && pin_match |=> tries[pidx] == 2'h3
    && o_sw_valid && o_sw == `SW_OK)
    else $error("attempts not restored");
  a_fail_status: assert property (
    ver_data && !blocked[pidx] && !pdis[pidx] && !pin_match |=> o_sw_valid
    && o_sw == {12'h63c, 2'b00, tries[pidx]} && tries[pidx] == $past(tries[pidx]) - 2'h1)
    else $error("failure status wrong");
  a_third_blocks: assert property (
    ver_data && !blocked[pidx] && !pdis[pidx] && !pin_match && tries[pidx] == 2'h1
    |=> blocked[pidx] && o_sw == 16'h63c0)
    else $error("PIN not blocked");
  a_blocked_answer: assert property (
    ver_data && blocked[pidx] |=> o_sw_valid && o_sw == 16'h6983
    && (psel != pidx || !needpin || pdis[psel] || !access_met) ##1 !o_sw_valid)
    else $error("blocked PIN answer wrong");
  a_query_quiet: assert property (
    st == ST_EXEC && ins_q == `INS_VER && lc_q == 8'h00 |=> $stable(tries[pidx])
    && $stable(blocked))
    else $error("query changed counters");
  a_bad_param: assert property (
    st == ST_EXEC && ins_q == `INS_INC && p2_q != 8'h00 |=> $stable(newest)
    && o_sw == 16'h6b00)
    else $error("bad parameter not refused");

endmodule

// File: test/rip_terminal.sv
// Terminal model that issues commands and takes the card's answers
`timescale 1ns/10ps

module rip_terminal
(
  input wire logic i_mclk,
  input wire logic i_busy,
  input wire logic i_resp_valid,
  input wire logic [7:0] i_resp_byte,
  input wire logic i_sw_valid,
  input wire logic [15:0] i_sw,
  output logic o_start,
  output logic [7:0] o_ins,
  output logic [7:0] o_p1,
  output logic [7:0] o_p2,
  output logic [7:0] o_lc,
  output logic o_dv,
  output logic [7:0] o_data,
  output logic o_ready
);
  initial
  begin
    o_start = 1'b0;
    o_ins = 8'h00;
    o_p1 = 8'h00;
    o_p2 = 8'h00;
    o_lc = 8'h00;
    o_dv = 1'b0;
    o_data = 8'h00;
    o_ready = 1'b0;
  end

  // ****
  // One command, answer collected with a stalling taker
  // ****
  task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] l, input logic [63:0] d, output logic [15:0] s,
    output logic [63:0] r, output logic t);
    int n;
    begin
      r = 64'h0;
      s = 16'h0000;
      t = 1'b1;
      for (n = 0; n < 50 && i_busy; n++)
        @(posedge i_mclk);
      o_start <= 1'b1;
      o_ins <= c;
      o_p1 <= a;
      o_p2 <= b;
      o_lc <= l;
      // exactly lc bytes, first most significant
      for (n = 0; n < l; n++)
      begin
        @(posedge i_mclk);
        o_start <= 1'b0;
        o_dv <= 1'b1;
        o_data <= d[8*(l-1-n) +: 8];
      end
      @(posedge i_mclk);
      o_start <= 1'b0;
      o_dv <= 1'b0;
      o_data <= ~o_data;
      o_ins <= ~c;
      o_p1 <= ~a;
      o_p2 <= ~b;
      o_lc <= ~l;
      for (n = 0; n < 300 && t; n++)
      begin
        @(posedge i_mclk);
        if (i_sw_valid)
        begin
          s = i_sw;
          t = 1'b0;
        end
        if (i_resp_valid && o_ready)
          r = {r[55:0], i_resp_byte};
        o_ready <= ~o_ready;
      end
    end
  endtask
endmodule

// File: test/record_increase_pin_verify_bench.sv
// Self-checking bench for the record increase and PIN verification block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module record_increase_pin_verify_bench;
  localparam logic [63:0] K0 = 64'h1122334455667788;
  localparam logic [63:0] K1 = 64'h0102030405060708;
  logic mclk, rst, nv, wr, rd, start, dv, busy, rv, rdy, swv;
  logic [7:0] addr, ins, p1, p2, lc, dat, rb;
  logic [31:0] wdata, rdata, q;
  logic [15:0] sw;
  int n_fail = 0;
  int n_tests = 0;

  record_increase_pin_verify i_dut (.i_mclk(mclk), .i_reset(rst), .i_nv_init(nv),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_cmd_start(start), .i_ins(ins), .i_p1(p1), .i_p2(p2), .i_lc(lc),
    .i_cmd_data_valid(dv), .i_cmd_data(dat), .o_cmd_busy(busy), .o_resp_valid(rv),
    .o_resp_byte(rb), .i_resp_ready(rdy), .o_sw_valid(swv), .o_sw(sw));

  rip_terminal i_term (.i_mclk(mclk), .i_busy(busy), .i_resp_valid(rv), .i_resp_byte(rb),
    .i_sw_valid(swv), .i_sw(sw), .o_start(start), .o_ins(ins), .o_p1(p1), .o_p2(p2),
    .o_lc(lc), .o_dv(dv), .o_data(dat), .o_ready(rdy));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ****
  // Bus, command and closing tasks
  // ****
  task automatic give_verdict();
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    begin
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      wdata <= ~d;
      @(posedge mclk);
    end
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    begin
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      d = rdata;
    end
  endtask

  task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] l, input logic [63:0] d, input logic [15:0] es, input logic [63:0] er);
    logic [15:0] s;
    logic [63:0] r;
    logic t;
    begin
      i_term.cmd(c, a, b, l, d, s, r, t);
      if (t)
      begin
        n_fail++;
        give_verdict();
      end
      `CHK("status word", es, s)
      `CHK("response", er, r)
    end
  endtask

  task automatic inc(input logic [7:0] a, input logic [7:0] l, input logic [63:0] d,
    input logic [15:0] es, input logic [63:0] er);
    run(8'h32, a, 8'h00, l, d, es, er);
  endtask

  task automatic ver(input logic [7:0] b, input logic [7:0] l, input logic [63:0] d,
    input logic [15:0] es);
    run(8'h20, 8'h00, b, l, d, es, 64'h0);
  endtask

  task automatic fill(input logic [31:0] v);
    for (int k = 0; k < 4; k++)
      reg_wr(8'h40 + 8'(4*k), v);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    begin
      reg_rd(8'h04, q);
      `CHK("fresh status", 32'h900000ff, q)
      reg_rd(8'h80, q);
      `CHK("unmapped", 32'h0, q)
      reg_wr(8'h00, 32'h501);
      reg_wr(8'h40, 32'h10);
      reg_wr(8'h10, K0[63:32]);
      reg_wr(8'h14, K0[31:0]);
      reg_wr(8'h18, K1[63:32]);
      reg_wr(8'h1c, K1[31:0]);
    end
  endtask

  task automatic t_increase();
    begin
      inc(8'h00, 8'h01, 64'h05, 16'h9000, 64'h0000001505);
      inc(8'h85, 8'h02, 64'h0101, 16'h9000, 64'h000001160101);
    end
  endtask

  task automatic t_refuse();
    begin
      inc(8'h86, 8'h01, 64'h01, 16'h6a82, 64'h0);
      inc(8'h40, 8'h01, 64'h01, 16'h6b00, 64'h0);
      run(8'h32, 8'h00, 8'h01, 8'h01, 64'h01, 16'h6b00, 64'h0);
      inc(8'h00, 8'h00, 64'h0, 16'h6700, 64'h0);
      inc(8'h00, 8'h05, 64'h01, 16'h6700, 64'h0);
      run(8'h00, 8'h00, 8'h00, 8'h00, 64'h0, 16'h6d00, 64'h0);
      inc(8'h00, 8'h01, 64'h01, 16'h9000, 64'h0000011701);
      reg_wr(8'h00, 32'h500);
      inc(8'h00, 8'h01, 64'h01, 16'h6982, 64'h0);
      reg_wr(8'h00, 32'h501);
      fill(32'hfffffffe);
      inc(8'h00, 8'h01, 64'h01, 16'h9000, 64'hffffffff01);
      inc(8'h00, 8'h01, 64'h01, 16'h9850, 64'h0);
      inc(8'h00, 8'h01, 64'h00, 16'h9000, 64'hffffffff00);
    end
  endtask

  task automatic t_pin();
    begin
      fill(32'h0);
      reg_wr(8'h00, 32'h503);
      inc(8'h00, 8'h01, 64'h01, 16'h6982, 64'h0);
      ver(8'h01, 8'h08, K0, 16'h9000);
      inc(8'h00, 8'h01, 64'h01, 16'h9000, 64'h0000000101);
      ver(8'h01, 8'h08, ~K0, 16'h63c2);
      inc(8'h00, 8'h01, 64'h01, 16'h6982, 64'h0);
      ver(8'h01, 8'h00, 64'h0, 16'h63c2);
      ver(8'h01, 8'h08, K0, 16'h9000);
      ver(8'h01, 8'h00, 64'h0, 16'h63c3);
      ver(8'h01, 8'h08, ~K0, 16'h63c2);
      // Keep newest pointer at record 1 while disabling PIN 0
      reg_wr(8'h00, 32'h10513);
      ver(8'h01, 8'h08, K0, 16'h6985);
      ver(8'h01, 8'h00, 64'h0, 16'h63c2);
      inc(8'h00, 8'h01, 64'h01, 16'h9000, 64'h0000000201);
      ver(8'h00, 8'h00, 64'h0, 16'h6b00);
      ver(8'h21, 8'h00, 64'h0, 16'h6b00);
      ver(8'h05, 8'h00, 64'h0, 16'h6a88);
    end
  endtask

  task automatic t_block();
    begin
      ver(8'h82, 8'h08, ~K1, 16'h63c2);
      ver(8'h82, 8'h08, ~K1, 16'h63c1);
      ver(8'h82, 8'h08, ~K1, 16'h63c0);
      ver(8'h82, 8'h08, K1, 16'h6983);
      ver(8'h02, 8'h00, 64'h0, 16'h6983);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      ver(8'h82, 8'h00, 64'h0, 16'h6983);
      reg_rd(8'h04, q);
      `CHK("kept status", 32'h698302f2, q)
    end
  endtask

  initial
  begin
    rst = 1'b1;
    nv = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    nv <= 1'b0;
    t_regs();
    t_increase();
    t_refuse();
    t_pin();
    t_block();
    give_verdict();
  end
endmodule
